// File: src/iesc_pkg.sv
// Package with register map, field positions and reset values of the enable logic.
package iesc_pkg;
   localparam int IESC_ADDR_W = 12;
   localparam int IESC_LIMIT_W = 8;
   localparam logic [11:0] IESC_RAW_OFF = 12'h000;
   localparam logic [11:0] IESC_MASKED_OFF = 12'h004;
   localparam logic [11:0] IESC_EN_SET_OFF = 12'h008;
   localparam logic [11:0] IESC_EN_CLR_OFF = 12'h00c;
   localparam logic [11:0] IESC_WAIT_CFG_OFF = 12'h010;
   localparam int IESC_TRAP_BIT = 2;
   localparam int IESC_TIMEOUT_BIT = 0;
   localparam logic [31:0] IESC_FLAG_MASK = 32'h0000_0005;
   localparam logic [31:0] IESC_ZERO = 32'h0000_0000;
   localparam logic [7:0] IESC_WAIT_LIMIT_RST = 8'h80;
   localparam logic [7:0] IESC_CNT_ZERO = 8'h00;
   localparam logic [7:0] IESC_CNT_ONE = 8'h01;
endpackage

// File: src/iesc_evt_if.sv
// Interface between the register block and the wait timeout detector.
`timescale 1ns/10ps
interface iesc_evt_if #(parameter int LIMIT_W = 8);
   logic access_active;
   logic wait_active;
   logic [LIMIT_W-1:0] limit;
   logic timeout_evt;
   modport ctl (output access_active, output wait_active, output limit, input timeout_evt);
   modport det (input access_active, input wait_active, input limit, output timeout_evt);
endinterface

// File: src/iesc_timeout.sv
// Wait timeout detector: flags a wait that outlasts the configured cycle limit.
`timescale 1ns/10ps
module iesc_timeout
   import iesc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   iesc_evt_if.det evt
);
   logic [IESC_LIMIT_W-1:0] cnt_ff;
   logic fired_ff;
   logic waiting;
   logic hit;

   assign waiting = evt.access_active && evt.wait_active;
   // One event per access: the detector stays quiet until the access ends.
   assign hit = waiting && !fired_ff && (cnt_ff == evt.limit);
   assign evt.timeout_evt = hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= IESC_CNT_ZERO;
      end else if (!waiting) begin
         cnt_ff <= IESC_CNT_ZERO;
      end else if (cnt_ff != evt.limit) begin
         cnt_ff <= cnt_ff + IESC_CNT_ONE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fired_ff <= 1'b0;
      end else if (!evt.access_active) begin
         fired_ff <= 1'b0;
      end else if (hit) begin
         fired_ff <= 1'b1;
      end
   end

   property p_timeout_cause;
      @(posedge pclk) disable iff (!presetn)
      evt.timeout_evt |-> waiting && cnt_ff == evt.limit;
   endproperty
   a_timeout_cause: assert property (p_timeout_cause)
      else $error("Timeout fired without an overlong wait.");

   property p_timeout_once;
      @(posedge pclk) disable iff (!presetn)
      evt.timeout_evt |=> !evt.timeout_evt;
   endproperty
   a_timeout_once: assert property (p_timeout_once)
      else $error("Timeout fired twice in a row.");
endmodule

// File: src/iesc_top.sv
// Interrupt enable set and clear registers with raw and enabled pending flags on APB.
//
// Overview of operation
// - Writing one to set register bit 2 enables trap; both registers read it.
// - Writing one to set register bit 0 enables timeout; both registers read it.
// - Writing one to clear register bit 2 disables trap; both registers read zero.
// - Writing one to clear register bit 0 disables timeout; both read zero.
// - Zero bits written to set or clear register leave the enables unchanged.
// - Timeout raw flag sets when the wait input outlasts the configured limit.
// - Enabled timeout flag sets only on timeout while its enable is one.
// - Enabled trap flag sets only on illegal access while its enable is one.
// - Writing one to an enabled flag clears it and its raw flag; zero does nothing.
`timescale 1ns/10ps
module iesc_top
   import iesc_pkg::*;
#(
   parameter int ADDR_W = IESC_ADDR_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic async_access_active,
   input wire logic external_wait_input,
   input wire logic illegal_access,
   output logic irq
);
   logic [31:0] raw_pending_flags_ff;
   logic [31:0] enabled_pending_flags_ff;
   logic [31:0] enable_ff;
   logic [IESC_LIMIT_W-1:0] wait_config_ff;
   logic [31:0] prdata_ff;
   logic [31:0] events;
   logic [31:0] raw_clear;
   logic [31:0] en_set_bits;
   logic [31:0] en_clr_bits;
   logic wr_access;
   logic mapped;
   logic [31:0] en_set_view;
   logic [31:0] en_clr_view;

   iesc_evt_if #(.LIMIT_W(IESC_LIMIT_W)) evt_bus ();

   function automatic logic hit_off(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
      hit_off = (addr[11:0] == off) && (addr >> 12 == '0);
   endfunction

   function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] addr);
      read_mux = IESC_ZERO;
      if (hit_off(addr, IESC_RAW_OFF)) begin
         read_mux = raw_pending_flags_ff;
      end else if (hit_off(addr, IESC_MASKED_OFF)) begin
         read_mux = enabled_pending_flags_ff;
      end else if (hit_off(addr, IESC_EN_SET_OFF) || hit_off(addr, IESC_EN_CLR_OFF)) begin
         read_mux = enable_ff;
      end else if (hit_off(addr, IESC_WAIT_CFG_OFF)) begin
         read_mux = {{(32 - IESC_LIMIT_W){1'b0}}, wait_config_ff};
      end
   endfunction

   assign evt_bus.access_active = async_access_active;
   assign evt_bus.wait_active = external_wait_input;
   assign evt_bus.limit = wait_config_ff;

   iesc_timeout u_timeout (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt_bus)
   );

   // The slave never inserts wait states, so every access completes in two cycles.
   assign mapped = hit_off(paddr, IESC_RAW_OFF) || hit_off(paddr, IESC_MASKED_OFF) ||
                   hit_off(paddr, IESC_EN_SET_OFF) || hit_off(paddr, IESC_EN_CLR_OFF) ||
                   hit_off(paddr, IESC_WAIT_CFG_OFF);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_ff;
   assign wr_access = psel && penable && pwrite;
   assign irq = |enabled_pending_flags_ff;

   always_comb begin
      events = IESC_ZERO;
      events[IESC_TRAP_BIT] = illegal_access;
      events[IESC_TIMEOUT_BIT] = evt_bus.timeout_evt;
   end

   // Reserved bits are masked off here, so they never store and always read zero.
   assign en_set_bits = (wr_access && hit_off(paddr, IESC_EN_SET_OFF)) ?
                        (pwdata & IESC_FLAG_MASK) : IESC_ZERO;
   assign en_clr_bits = (wr_access && hit_off(paddr, IESC_EN_CLR_OFF)) ?
                        (pwdata & IESC_FLAG_MASK) : IESC_ZERO;
   // A clear through either status view drops both flags together.
   assign raw_clear = (wr_access && (hit_off(paddr, IESC_RAW_OFF) ||
                      hit_off(paddr, IESC_MASKED_OFF))) ?
                      (pwdata & IESC_FLAG_MASK) : IESC_ZERO;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_ff <= IESC_ZERO;
      end else begin
         enable_ff <= (enable_ff | en_set_bits) & ~en_clr_bits;
      end
   end

   // An event in the same cycle as its clear survives: the set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_pending_flags_ff <= IESC_ZERO;
      end else begin
         raw_pending_flags_ff <= (raw_pending_flags_ff & ~raw_clear) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enabled_pending_flags_ff <= IESC_ZERO;
      end else begin
         enabled_pending_flags_ff <= (enabled_pending_flags_ff & ~raw_clear) |
                                     (events & enable_ff);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_config_ff <= IESC_WAIT_LIMIT_RST;
      end else if (wr_access && hit_off(paddr, IESC_WAIT_CFG_OFF)) begin
         wait_config_ff <= pwdata[IESC_LIMIT_W-1:0];
      end
   end

   // Read data is captured in the setup cycle and held through the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= IESC_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= read_mux(paddr);
      end
   end

   // Both enable views come through the read path, so the checks cover the mux as well.
   always_comb begin
      en_set_view = read_mux(IESC_EN_SET_OFF);
      en_clr_view = read_mux(IESC_EN_CLR_OFF);
   end

   sequence s_wr_bit(logic [11:0] off, int b);
      wr_access && hit_off(paddr, off) && pwdata[b];
   endsequence

   sequence s_both_read(int b, logic v);
      en_set_view[b] == v && en_clr_view[b] == v;
   endsequence

   property p_trap_set;
      @(posedge pclk) disable iff (!presetn)
      s_wr_bit(IESC_EN_SET_OFF, IESC_TRAP_BIT) |=> s_both_read(IESC_TRAP_BIT, 1'b1);
   endproperty
   a_trap_set: assert property (p_trap_set)
      else $error("Trap enable did not set.");

   property p_timeout_set;
      @(posedge pclk) disable iff (!presetn)
      s_wr_bit(IESC_EN_SET_OFF, IESC_TIMEOUT_BIT) |=> s_both_read(IESC_TIMEOUT_BIT, 1'b1);
   endproperty
   a_timeout_set: assert property (p_timeout_set)
      else $error("Timeout enable did not set.");

   property p_trap_clr;
      @(posedge pclk) disable iff (!presetn)
      s_wr_bit(IESC_EN_CLR_OFF, IESC_TRAP_BIT) |=> s_both_read(IESC_TRAP_BIT, 1'b0);
   endproperty
   a_trap_clr: assert property (p_trap_clr)
      else $error("Trap enable did not clear.");

   property p_timeout_clr;
      @(posedge pclk) disable iff (!presetn)
      s_wr_bit(IESC_EN_CLR_OFF, IESC_TIMEOUT_BIT) |=> s_both_read(IESC_TIMEOUT_BIT, 1'b0);
   endproperty
   a_timeout_clr: assert property (p_timeout_clr)
      else $error("Timeout enable did not clear.");

   property p_zero_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_access && (hit_off(paddr, IESC_EN_SET_OFF) || hit_off(paddr, IESC_EN_CLR_OFF)) &&
       (pwdata & IESC_FLAG_MASK) == IESC_ZERO) |=> $stable(enable_ff);
   endproperty
   a_zero_write: assert property (p_zero_write)
      else $error("Zero write changed the enables.");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
      (enable_ff & ~IESC_FLAG_MASK) == IESC_ZERO;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved enable bit is set.");

   property p_timeout_masked;
      @(posedge pclk) disable iff (!presetn)
      $rose(enabled_pending_flags_ff[IESC_TIMEOUT_BIT]) |->
         $past(evt_bus.timeout_evt) && $past(enable_ff[IESC_TIMEOUT_BIT]);
   endproperty
   a_timeout_masked: assert property (p_timeout_masked)
      else $error("Enabled timeout flag set without an enabled event.");

   property p_trap_masked;
      @(posedge pclk) disable iff (!presetn)
      $rose(enabled_pending_flags_ff[IESC_TRAP_BIT]) |->
         $past(illegal_access) && $past(enable_ff[IESC_TRAP_BIT]);
   endproperty
   a_trap_masked: assert property (p_trap_masked)
      else $error("Enabled trap flag set without an enabled event.");

   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
      s_wr_bit(IESC_MASKED_OFF, IESC_TIMEOUT_BIT) ##0 !evt_bus.timeout_evt |=>
         !raw_pending_flags_ff[IESC_TIMEOUT_BIT] && !enabled_pending_flags_ff[IESC_TIMEOUT_BIT];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Flag clear did not drop both flags.");
endmodule

// File: bench/iesc_top_tb.sv
// Self-checking testbench for the interrupt enable set and clear registers.
`timescale 1ns/10ps
module iesc_top_tb
   import iesc_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic async_access_active, external_wait_input, illegal_access;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int fail_count, n_checks, cycles;

   iesc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .async_access_active(async_access_active),
      .external_wait_input(external_wait_input), .illegal_access(illegal_access), .irq(irq));

   always #12.5 pclk = ~pclk;

   // A hung handshake would stall the run, so a cycle ceiling ends it.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The request is held until pready is seen high, then released at that edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   task automatic en_chk(input logic [31:0] exp);
      rd_chk(IESC_EN_SET_OFF, exp);
      rd_chk(IESC_EN_CLR_OFF, exp);
   endtask

   task automatic irq_chk(input logic exp);
      @(negedge pclk);
      check({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic trap_pulse();
      @(posedge pclk);
      illegal_access <= 1'b1;
      @(posedge pclk);
      illegal_access <= 1'b0;
   endtask

   task automatic wait_for(input int n);
      @(posedge pclk);
      async_access_active <= 1'b1;
      external_wait_input <= 1'b1;
      repeat (n) @(posedge pclk);
      async_access_active <= 1'b0;
      external_wait_input <= 1'b0;
   endtask

   task automatic test_enable();
      en_chk(32'h0000_0000);
      apb(1'b1, IESC_EN_SET_OFF, 32'hffff_ffff);
      en_chk(32'h0000_0005);
      apb(1'b1, IESC_EN_CLR_OFF, 32'h0000_0000);
      en_chk(32'h0000_0005);
      apb(1'b1, IESC_EN_CLR_OFF, 32'hffff_fffa);
      en_chk(32'h0000_0005);
      apb(1'b1, IESC_EN_CLR_OFF, 32'h0000_0004);
      en_chk(32'h0000_0001);
      apb(1'b1, IESC_EN_SET_OFF, 32'h0000_0000);
      en_chk(32'h0000_0001);
      apb(1'b1, IESC_EN_CLR_OFF, 32'h0000_0001);
      en_chk(32'h0000_0000);
      $display("test enable done");
   endtask

   task automatic test_trap();
      apb(1'b1, IESC_EN_SET_OFF, 32'h0000_0004);
      trap_pulse();
      rd_chk(IESC_MASKED_OFF, 32'h0000_0004);
      irq_chk(1'b1);
      apb(1'b1, IESC_MASKED_OFF, 32'h0000_0000);
      rd_chk(IESC_RAW_OFF, 32'h0000_0004);
      apb(1'b1, IESC_MASKED_OFF, 32'h0000_0004);
      rd_chk(IESC_RAW_OFF, 32'h0000_0000);
      rd_chk(IESC_MASKED_OFF, 32'h0000_0000);
      irq_chk(1'b0);
      apb(1'b1, IESC_EN_CLR_OFF, 32'h0000_0004);
      trap_pulse();
      rd_chk(IESC_RAW_OFF, 32'h0000_0004);
      rd_chk(IESC_MASKED_OFF, 32'h0000_0000);
      irq_chk(1'b0);
      apb(1'b1, IESC_RAW_OFF, 32'h0000_0004);
      $display("test trap done");
   endtask

   task automatic test_timeout();
      rd_chk(IESC_WAIT_CFG_OFF, {24'h00_0000, IESC_WAIT_LIMIT_RST});
      apb(1'b1, IESC_WAIT_CFG_OFF, 32'h0000_0003);
      rd_chk(IESC_WAIT_CFG_OFF, 32'h0000_0003);
      apb(1'b1, IESC_EN_SET_OFF, 32'h0000_0001);
      wait_for(3);
      rd_chk(IESC_RAW_OFF, 32'h0000_0000);
      wait_for(4);
      rd_chk(IESC_RAW_OFF, 32'h0000_0001);
      rd_chk(IESC_MASKED_OFF, 32'h0000_0001);
      irq_chk(1'b1);
      apb(1'b1, IESC_MASKED_OFF, 32'h0000_0001);
      rd_chk(IESC_RAW_OFF, 32'h0000_0000);
      apb(1'b1, IESC_EN_CLR_OFF, 32'h0000_0001);
      wait_for(6);
      rd_chk(IESC_MASKED_OFF, 32'h0000_0000);
      irq_chk(1'b0);
      $display("test timeout done");
   endtask

   task automatic test_unmapped();
      apb(1'b0, 12'h020, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      $display("test unmapped done");
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, async_access_active, external_wait_input} = 5'h00;
      illegal_access = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_enable();
      test_trap();
      test_timeout();
      test_unmapped();
      stop_test();
   end
endmodule
